// ---- design/dee_defines.svh ----
// Offsets, field positions, reset values and timing of the data EEPROM controller
`ifndef DEE_DEFINES_SVH
`define DEE_DEFINES_SVH

`define DEE_ADDR_W 9
`define DEE_ARR_DEPTH 256
`define DEE_LATCH_N 16
`define DEE_CTRL_ADDR 9'h100
`define DEE_STAT_ADDR 9'h101
`define DEE_MASK_ADDR 9'h102
`define DEE_CTRL_PGM 0
`define DEE_CTRL_LAT 1
`define DEE_CTRL_IE 2
`define DEE_STAT_DONE 0
`define DEE_STAT_BUSY 1
`define DEE_STAT_WAIT 2
`define DEE_STAT_HALT 3
`define DEE_CTRL_RESET 8'h00
`define DEE_STAT_RESET 8'h00
`define DEE_MASK_RESET 8'h00
`define DEE_CLK_PERIOD_NS 4
`define DEE_PROG_TIME_NS 5000000
`define DEE_PROG_CYCLES ((`DEE_PROG_TIME_NS + `DEE_CLK_PERIOD_NS - 1) / `DEE_CLK_PERIOD_NS)

`endif

// ---- design/dee_pkg.sv ----
// Types shared by the data EEPROM controller modules
package dee_pkg;

    typedef logic [7:0] dee_byte_t;
    typedef logic [3:0] dee_idx_t;
    typedef logic [3:0] dee_row_t;

    typedef enum logic [1:0] {
        DEE_RUN,
        DEE_WAIT,
        DEE_HALT
    } dee_pwr_t;

endpackage

// ---- design/dee_prog_if.sv ----
// Interface joining controller, byte latches and cell array
`timescale 1ns/1ps
interface dee_prog_if;
    import dee_pkg::*;

    logic wr_en;
    dee_idx_t wr_idx;
    dee_byte_t wr_data;
    logic clr;
    dee_row_t row;
    logic commit;
    dee_byte_t data [16];
    logic [15:0] valid;

    modport ctrl (output wr_en, output wr_idx, output wr_data, output clr,
                  output row, output commit);
    modport latch (input wr_en, input wr_idx, input wr_data, input clr,
                   output data, output valid);
    modport array (input row, input commit, input data, input valid);
endinterface

// ---- design/dee_latches.sv ----
// Sixteen write-only byte latches of one EEPROM row
`timescale 1ns/1ps
module dee_latches
    import dee_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    dee_prog_if.latch lif
);

    dee_byte_t data_r [16];
    logic [15:0] valid_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_r <= 16'h0000;
            for (int i = 0; i < 16; i++) begin
                data_r[i] <= 8'hff;
            end
        end else if (lif.clr) begin
            valid_r <= 16'h0000;
            for (int i = 0; i < 16; i++) begin
                data_r[i] <= 8'hff;
            end
        end else if (lif.wr_en) begin
            // Cleared latches hold all ones, so AND also gives the first load
            data_r[lif.wr_idx] <= data_r[lif.wr_idx] & lif.wr_data; // RULE6
            valid_r[lif.wr_idx] <= 1'b1; // RULE2
        end
    end

    assign lif.valid = valid_r;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            lif.data[i] = data_r[i];
        end
    end

endmodule

// ---- design/dee_array.sv ----
// Cell array of 256 bytes, programmed one row at a time
`timescale 1ns/1ps
module dee_array
    import dee_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rd_addr,
    output dee_byte_t rd_data,
    dee_prog_if.array pif
);

    // No reset: nonvolatile contents survive a reset
    dee_byte_t mem [256];

    always_ff @(posedge clk) begin
        if (pif.commit) begin
            for (int i = 0; i < 16; i++) begin
                if (pif.valid[i]) begin
                    mem[{pif.row, 4'(i)}] <= pif.data[i]; // RULE3
                end
            end
        end
    end

    assign rd_data = mem[rd_addr];

endmodule

// ---- design/dee_ctrl.sv ----
// Data EEPROM write controller: bus decode, control, timing, power modes, interrupt
//
// Notes on behaviour
// RULE1: With write-latch mode off, an array read returns the addressed byte like ROM.
// RULE2: Set write-latch mode alone; each array write then fills one of sixteen latches.
// RULE3: Setting program-start programs all latched bytes into the row of the last write.
// RULE4: Software keeps all latched writes within one row; only low four bits differ.
// RULE5: Cycle end clears program-start and latch mode together; raises request if enabled.
// RULE6: Latches clear at cycle end or latch-mode fall; repeat writes AND together.
// RULE7: Latch contents can never be read back.
// RULE8: Array reads during write-latch mode leave the data bus undriven.
// RULE9: Array writes while write-latch mode is off are ignored.
// RULE10: Software must not clear program-start or reset during a running cycle.
// RULE11: Wait request enters wait at once if idle, else after the cycle ends.
// RULE12: Halt request stops at once and abandons any running cycle.
// RULE13: Completion interrupt wakes from wait, never from halt.
// RULE14: Completion interrupt reaches the core only if enabled and core unmasked.
// RULE15: Control resets to zero; bits 7:3 read zero; 2 enable, 1 latch, 0 start.
// RULE16: Completion request withdraws itself when the core enters the service routine.
// RULE17: Latch mode set by software only; software clear works only with start low.
// RULE18: Writing start launches the cycle; start reads one throughout, zero otherwise.
// RULE19: Cycle length is a counted parameter; charge pump enabled for that period.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "dee_defines.svh"
module dee_ctrl
    import dee_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `DEE_PROG_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [`DEE_ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic bus_rdata_oe,
    input wire logic cpu_i_mask,
    input wire logic irq_ack,
    input wire logic wfi_req,
    input wire logic halt_req,
    input wire logic wake_in,
    output logic irq,
    output logic wake_cpu,
    output logic charge_pump_en,
    output logic wait_state,
    output logic halt_state
);

    // Register packing, shared by the read mux
    function automatic dee_byte_t pack_ctrl(input logic ie, input logic lat, input logic pgm);
        dee_byte_t v;
        v = `DEE_CTRL_RESET;
        v[`DEE_CTRL_IE] = ie;
        v[`DEE_CTRL_LAT] = lat;
        v[`DEE_CTRL_PGM] = pgm;
        return v;
    endfunction

    function automatic dee_byte_t pack_stat(input logic done, input logic busy,
                                            input logic wt, input logic hl);
        dee_byte_t v;
        v = `DEE_STAT_RESET;
        v[`DEE_STAT_DONE] = done;
        v[`DEE_STAT_BUSY] = busy;
        v[`DEE_STAT_WAIT] = wt;
        v[`DEE_STAT_HALT] = hl;
        return v;
    endfunction

    dee_prog_if pif ();

    logic lat_r;
    logic lat_q_r;
    logic pgm_r;
    logic ie_r;
    logic done_r;
    logic mask_r;
    logic wait_pend_r;
    dee_pwr_t state_r;
    logic [31:0] cnt_r;
    dee_row_t row_r;
    dee_byte_t rdata_r;
    logic rdata_oe_r;
    dee_byte_t arr_rdata;

    logic sel_arr;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_mask;
    logic ctrl_wr;
    logic arr_wr;
    logic prog_end;
    logic halt_go;
    logic wait_go;
    logic done_set;
    logic done_clr;
    logic pgm_wr_set;
    logic pgm_wr_clr;
    logic lat_wr_set;
    logic lat_wr_clr;
    logic stat_wr;
    logic mask_wr;

    always_comb begin
        sel_arr = 1'b0;
        sel_ctrl = 1'b0;
        sel_stat = 1'b0;
        sel_mask = 1'b0;
        if (bus_addr[`DEE_ADDR_W-1] == 1'b0) begin
            sel_arr = 1'b1;
        end else if (bus_addr == `DEE_CTRL_ADDR) begin
            sel_ctrl = 1'b1;
        end else if (bus_addr == `DEE_STAT_ADDR) begin
            sel_stat = 1'b1;
        end else if (bus_addr == `DEE_MASK_ADDR) begin
            sel_mask = 1'b1;
        end
    end

    assign ctrl_wr = bus_wr && sel_ctrl;
    assign arr_wr = bus_wr && sel_arr && lat_r; // RULE9

    // Start refused unless latch mode is on or set by the same write
    assign pgm_wr_set = ctrl_wr && bus_wdata[`DEE_CTRL_PGM]
        && (lat_r || bus_wdata[`DEE_CTRL_LAT]);
    assign pgm_wr_clr = ctrl_wr && !bus_wdata[`DEE_CTRL_PGM];
    assign lat_wr_set = ctrl_wr && bus_wdata[`DEE_CTRL_LAT];
    // Dropping latch mode mid-cycle would clear latches under the cells
    assign lat_wr_clr = ctrl_wr && !bus_wdata[`DEE_CTRL_LAT] && !pgm_r; // RULE17
    assign stat_wr = bus_wr && sel_stat;
    assign mask_wr = bus_wr && sel_mask;
    // Halt freezes the timer, so the cycle can only end outside halt
    assign prog_end = pgm_r && (state_r != DEE_HALT) && (cnt_r == PROG_CYCLES - 1); // RULE19
    assign halt_go = halt_req && (state_r != DEE_HALT);

    // Programming timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h0000_0000;
        end else if (!pgm_r || prog_end) begin
            cnt_r <= 32'h0000_0000;
        end else if (state_r != DEE_HALT) begin
            cnt_r <= cnt_r + 32'h0000_0001; // RULE19
        end
    end

    // Program-start bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pgm_r <= 1'b0; // RULE15
        end else if (halt_go) begin
            pgm_r <= 1'b0; // RULE12
        end else if (prog_end) begin
            pgm_r <= 1'b0; // RULE5
        end else if (pgm_wr_set) begin
            pgm_r <= 1'b1; // RULE18
        end else if (pgm_wr_clr) begin
            // Aborts a running cycle; row left unprogrammed
            pgm_r <= 1'b0;
        end
    end

    // Write-latch mode bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lat_r <= 1'b0; // RULE15
        end else if (halt_go) begin
            lat_r <= 1'b0; // RULE12
        end else if (prog_end) begin
            lat_r <= 1'b0; // RULE5
        end else if (lat_wr_set) begin
            lat_r <= 1'b1; // RULE17
        end else if (lat_wr_clr) begin
            lat_r <= 1'b0; // RULE17
        end
    end

    // Delayed copy for the falling-edge latch clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lat_q_r <= 1'b0;
        end else begin
            lat_q_r <= lat_r;
        end
    end

    // Interrupt enable bit
    // Free to change mid-cycle; only its value at cycle end counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ie_r <= 1'b0; // RULE15
        end else if (ctrl_wr) begin
            ie_r <= bus_wdata[`DEE_CTRL_IE];
        end
    end

    // Row of the most recent latched write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            row_r <= 4'h0;
        end else if (arr_wr) begin
            // Only the last row survives; mixed rows program the wrong cells
            row_r <= bus_addr[7:4]; // RULE3
        end
    end

    // Latches clear on cycle end and on the falling edge of latch mode
    assign pif.wr_en = arr_wr; // RULE2
    assign pif.wr_idx = bus_addr[3:0];
    assign pif.wr_data = bus_wdata;
    assign pif.clr = prog_end || (lat_q_r && !lat_r); // RULE6
    assign pif.row = row_r;
    assign pif.commit = prog_end; // RULE3

    dee_latches u_latches (
        .clk(clk),
        .rst(rst),
        .lif(pif)
    );

    dee_array u_array (
        .clk(clk),
        .rd_addr(bus_addr[7:0]),
        .rd_data(arr_rdata),
        .pif(pif)
    );

    // Completion status: set wins over any clear in the same cycle
    assign done_set = prog_end && ie_r; // RULE5
    assign done_clr = (stat_wr && bus_wdata[`DEE_STAT_DONE]) || irq_ack; // RULE16

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (done_set) begin
            done_r <= 1'b1;
        end else if (done_clr) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_r <= 1'b0;
        end else if (mask_wr) begin
            mask_r <= bus_wdata[`DEE_STAT_DONE];
        end
    end

    // Level request; acknowledge or a written one clears it
    assign irq = done_r && mask_r && !cpu_i_mask; // RULE14

    // Power modes
    assign wait_go = (wfi_req || wait_pend_r) && (!pgm_r || prog_end); // RULE11

    // Request during a cycle is held so the cells finish cleanly
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_pend_r <= 1'b0;
        end else if (halt_go || wait_go) begin
            wait_pend_r <= 1'b0;
        end else if (wfi_req && (state_r == DEE_RUN)) begin
            wait_pend_r <= 1'b1; // RULE11
        end
    end

    // Halt outranks wait and drops any pending wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= DEE_RUN;
        end else begin
            case (state_r)
                DEE_RUN: begin
                    if (halt_req) begin
                        state_r <= DEE_HALT; // RULE12
                    end else if (wait_go) begin
                        state_r <= DEE_WAIT; // RULE11
                    end
                end
                DEE_WAIT: begin
                    if (halt_req) begin
                        state_r <= DEE_HALT;
                    end else if (done_r || wake_in) begin
                        // Wake needs no core unmask, only the local enable
                        state_r <= DEE_RUN; // RULE13
                    end
                end
                DEE_HALT: begin
                    // Own completion request cannot leave halt
                    if (wake_in) begin
                        state_r <= DEE_RUN; // RULE13
                    end
                end
                default: begin
                    state_r <= DEE_RUN;
                end
            endcase
        end
    end

    assign wake_cpu = (state_r == DEE_WAIT) && done_r; // RULE13
    assign wait_state = (state_r == DEE_WAIT);
    assign halt_state = (state_r == DEE_HALT);
    assign charge_pump_en = pgm_r; // RULE19

    // Read port: answer in the following cycle only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
            rdata_oe_r <= 1'b0;
        end else if (!bus_rd) begin
            rdata_r <= 8'h00;
            rdata_oe_r <= 1'b0;
        end else if (sel_arr) begin
            // Latch contents never reach this mux
            if (lat_r) begin
                rdata_r <= 8'h00; // RULE7
                rdata_oe_r <= 1'b0; // RULE8
            end else begin
                rdata_r <= arr_rdata; // RULE1
                rdata_oe_r <= 1'b1;
            end
        end else if (sel_ctrl) begin
            rdata_r <= pack_ctrl(ie_r, lat_r, pgm_r); // RULE15
            rdata_oe_r <= 1'b1;
        end else if (sel_stat) begin
            rdata_r <= pack_stat(done_r, pgm_r, state_r == DEE_WAIT, state_r == DEE_HALT);
            rdata_oe_r <= 1'b1;
        end else if (sel_mask) begin
            rdata_r <= {7'h00, mask_r};
            rdata_oe_r <= 1'b1;
        end else begin
            // Unmapped addresses answer zero with the bus driven
            rdata_r <= 8'h00;
            rdata_oe_r <= 1'b1;
        end
    end

    assign bus_rdata = rdata_r;
    assign bus_rdata_oe = rdata_oe_r;

endmodule

// ---- verification/dee_ctrl_properties.sv ----
// Concurrent checks on the data EEPROM controller ports
`timescale 1ns/1ps
`include "dee_defines.svh"
module dee_ctrl_properties #(
    parameter int unsigned PROG_CYCLES = 20
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [`DEE_ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_rdata_oe,
    input wire logic cpu_i_mask,
    input wire logic irq_ack,
    input wire logic wfi_req,
    input wire logic halt_req,
    input wire logic wake_in,
    input wire logic irq,
    input wire logic wake_cpu,
    input wire logic charge_pump_en,
    input wire logic wait_state,
    input wire logic halt_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    int unsigned pump_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pump_cnt <= 0;
        else if (charge_pump_en) pump_cnt <= pump_cnt + 1;
        else pump_cnt <= 0;
    end
    property p_ctrl_read; bus_rd && bus_addr == 9'h100 |=> bus_rdata_oe && bus_rdata[7:3] == 5'h00; endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read bad");
    property p_idle_bus; !bus_rd |=> bus_rdata == 8'h00 && !bus_rdata_oe; endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("read data outside slot");
    property p_masked; cpu_i_mask |-> !irq; endproperty
    a_masked: assert property (p_masked) else $error("irq while masked");
    property p_pump_min; $rose(charge_pump_en) |-> (charge_pump_en || halt_state) [*8]; endproperty
    a_pump_min: assert property (p_pump_min) else $error("pump too short");
    property p_pump_len;
        $fell(charge_pump_en) && !$past(halt_req) && !$past(bus_wr, 1) |-> pump_cnt == PROG_CYCLES;
    endproperty
    a_pump_len: assert property (p_pump_len) else $error("cycle length wrong");
    property p_wait_idle;
        wfi_req && !halt_req && !charge_pump_en && !halt_state && !wake_in |=> wait_state;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("no wait when idle");
    property p_wait_busy;
        wfi_req && charge_pump_en && !wait_state |=> !wait_state || !charge_pump_en;
    endproperty
    a_wait_busy: assert property (p_wait_busy) else $error("wait during cycle");
    property p_halt; halt_req && !wake_in |=> halt_state && !charge_pump_en; endproperty
    a_halt: assert property (p_halt) else $error("halt not at once");
    property p_no_halt_wake; halt_state && !wake_in |=> halt_state && !wake_cpu; endproperty
    a_no_halt_wake: assert property (p_no_halt_wake) else $error("woke from halt");
    property p_ack; irq_ack && !charge_pump_en |=> !irq; endproperty
    a_ack: assert property (p_ack) else $error("irq kept after ack");
endmodule

// ---- verification/dee_cpu_model.sv ----
// Core side: enters the service routine a few cycles after irq
`timescale 1ns/1ps
module dee_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq,
    output logic irq_ack
);
    logic [2:0] lat_r;
    // Latency stands for finishing the current instruction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lat_r <= 3'h0;
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= irq && lat_r == 3'h3 && !irq_ack;
            lat_r <= (irq && !irq_ack) ? lat_r + 3'h1 : 3'h0;
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the data EEPROM controller
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned PROG_CYCLES = 20;
    logic clk = 0, rst = 1, bus_wr = 0, bus_rd = 0, cpu_i_mask = 1;
    logic wfi_req = 0, halt_req = 0, wake_in = 0;
    logic [8:0] bus_addr = 9'h000;
    logic [7:0] bus_wdata = 8'h00, bus_rdata, d;
    logic bus_rdata_oe, irq_ack, irq, wake_cpu, charge_pump_en, wait_state, halt_state;
    int n_mismatch = 0, checked = 0, cyc = 0;
    always #2 clk = ~clk;
    dee_ctrl #(.PROG_CYCLES(PROG_CYCLES)) u_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .bus_rdata_oe(bus_rdata_oe), .cpu_i_mask(cpu_i_mask), .irq_ack(irq_ack),
        .wfi_req(wfi_req), .halt_req(halt_req), .wake_in(wake_in), .irq(irq),
        .wake_cpu(wake_cpu), .charge_pump_en(charge_pump_en), .wait_state(wait_state),
        .halt_state(halt_state));
    dee_cpu_model u_cpu (.clk(clk), .rst(rst), .irq(irq), .irq_ack(irq_ack));
    task automatic chk(logic [7:0] g, logic [7:0] e);
        checked++;
        if (g !== e) begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            n_mismatch++;
        end
    endtask
    task automatic wr(logic [8:0] a, logic [7:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1;
        @(posedge clk);
        bus_wr <= 0;
    endtask
    task automatic rd(logic [8:0] a, logic oe);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1;
        @(posedge clk);
        bus_rd <= 0;
        #1 d = bus_rdata;
        chk(bus_rdata_oe, oe);
    endtask
    // 0 wait request, 1 wake, 2 halt
    task automatic pulse(int k);
        @(posedge clk);
        if (k == 0) wfi_req <= 1;
        else if (k == 1) wake_in <= 1;
        else halt_req <= 1;
        @(posedge clk);
        wfi_req <= 0;
        wake_in <= 0;
        halt_req <= 0;
        #1;
    endtask
    task automatic wait_pump;
        for (int i = 0; i < 200 && charge_pump_en === 1'b1; i++) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        rd(9'h100, 1); chk(d, 8'h00);
        rd(9'h101, 1); chk(d, 8'h00);
        rd(9'h102, 1); chk(d, 8'h00);
        rd(9'h1ff, 1); chk(d, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_program;
        wr(9'h102, 8'h01);
        wr(9'h100, 8'h02);
        wr(9'h035, 8'ha5);
        wr(9'h035, 8'hf0);
        wr(9'h03a, 8'h3c);
        rd(9'h035, 0); chk(d, 8'h00);
        wr(9'h100, 8'h07);
        rd(9'h100, 1); chk(d, 8'h07);
        wait_pump;
        rd(9'h100, 1); chk(d, 8'h04);
        chk(irq, 0);
        rd(9'h101, 1); chk(d[0], 1);
        @(posedge clk) cpu_i_mask <= 0;
        @(posedge clk) #1 chk(irq, 1);
        repeat (6) @(posedge clk);
        #1 chk(irq, 0);
        rd(9'h035, 1); chk(d, 8'ha0);
        rd(9'h03a, 1); chk(d, 8'h3c);
        $display("test program done");
    endtask
    task automatic t_ignore;
        wr(9'h035, 8'h00);
        rd(9'h035, 1); chk(d, 8'ha0);
        $display("test ignore done");
    endtask
    task automatic t_wait;
        pulse(0); chk(wait_state, 1);
        pulse(1); chk(wait_state, 0);
        wr(9'h100, 8'h02);
        wr(9'h050, 8'h11);
        wr(9'h100, 8'h03);
        pulse(0); chk(wait_state, 0);
        wait_pump;
        @(posedge clk) #1 chk(wait_state, 1);
        pulse(1); chk(wait_state, 0);
        rd(9'h050, 1); chk(d, 8'h11);
        wr(9'h100, 8'h02);
        wr(9'h070, 8'h33);
        wr(9'h100, 8'h07);
        cpu_i_mask <= 1;
        pulse(0); chk(wait_state, 0);
        @(negedge charge_pump_en) #1 chk(wake_cpu, 1);
        chk(wait_state, 1);
        @(posedge clk) #1 chk(wait_state, 0);
        rd(9'h101, 1); chk(d, 8'h01);
        wr(9'h101, 8'h01);
        rd(9'h101, 1); chk(d, 8'h00);
        rd(9'h070, 1); chk(d, 8'h33);
        $display("test wait done");
    endtask
    task automatic t_halt;
        wr(9'h100, 8'h02);
        wr(9'h060, 8'h22);
        wr(9'h100, 8'h07);
        wr(9'h100, 8'h05);
        rd(9'h100, 1); chk(d, 8'h07);
        repeat (6) @(posedge clk);
        pulse(2); chk(halt_state, 1);
        chk(charge_pump_en, 0);
        repeat (30) @(posedge clk);
        #1 chk(halt_state, 1);
        chk(wake_cpu, 0);
        pulse(1); chk(halt_state, 0);
        rd(9'h100, 1); chk(d, 8'h04);
        $display("test halt done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            stop_test;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        t_reset;
        t_program;
        t_ignore;
        t_wait;
        t_halt;
        stop_test;
    end
endmodule
bind dee_ctrl dee_ctrl_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (.clk(clk), .rst(rst),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .bus_rdata_oe(bus_rdata_oe), .cpu_i_mask(cpu_i_mask), .irq_ack(irq_ack),
    .wfi_req(wfi_req), .halt_req(halt_req), .wake_in(wake_in), .irq(irq),
    .wake_cpu(wake_cpu), .charge_pump_en(charge_pump_en), .wait_state(wait_state),
    .halt_state(halt_state));
